// ==== logic/mailbox_map.svh ====
// constants for the command mailbox: link register offsets, command codes,
// table layout and the host's apb map; assumes inclusion by both ends.
// Operation
// - only 7-bit address, 0x53 or 0x52 strap
// - programmed address reverts on any reset
// - table volatile, defaults restored on soft reset
// - table reached only through command codes
// - error on bad location or oversized output
// - counter increments on error-free completion
// - host reads response after every command
// - host clears error with clear or reset
// - host may clear counter before commands
// - host loads argument before command code
// - table write stores staging byte, echoes result
// - table write also puts value in result
// - table read places byte in result
// - new address takes seven low bits
// - new address answered at once, kept
// - clear command zeroes completion counter
// - soft reset restores power-up, counter 0x0f
// - single shot on enabled unindexed channels
// - pause stops autonomous enabled channels
// - start runs enabled indexed channels periodically
// - table location is six low bits
// - counter in bits 3:0, skips clear/reset
// - clear command also clears error flag
`ifndef MAILBOX_MAP_SVH
`define MAILBOX_MAP_SVH
`define PRIMARY_ADDR 7'h53
`define ALTERNATE_ADDR 7'h52
`define REG_STAGING 8'h0a
`define REG_COMMAND 8'h0b
`define REG_RESULT 8'h10
`define REG_RESPONSE 8'h11
`define RESPONSE_RESET 8'h2f
`define ERR_BIT 4
`define CMD_CLEAR 8'h00
`define CMD_SOFT_RESET 8'h01
`define CMD_NEW_ADDR 8'h02
`define CMD_FORCE 8'h11
`define CMD_PAUSE 8'h12
`define CMD_START 8'h13
`define CMD_READ_TAG 2'h1
`define CMD_WRITE_TAG 2'h2
`define TABLE_DEPTH 64
`define TABLE_LAST 6'h2d
`define TABLE_DEFAULT 8'h00
`define LOC_NEW_ADDR 6'h00
`define LOC_CHANNEL_ENABLE_LIST 6'h01
`define LOC_ADCPOST0 6'h04
`define LOC_MEASCFG0 6'h05
`define LOC_STRIDE 4
`define LOC_BURST 6'h2b
`define WIDE_BIT 6
`define BURST_BIT 7
`define CHANNELS 6
`define OUT_AREA 7'd26
`define INIT_DONE 2'h3
`define APB_ACCESS 12'h000
`define APB_STATUS 12'h004
`define ACC_WR_BIT 24
`endif

// ==== logic/mailbox_pkg.sv ====
// shared types of the command mailbox; assumes mailbox_map.svh beside it.
package mailbox_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] bus_addr_t;
  typedef enum {K_CLEAR, K_SOFT, K_NEW_ADDR, K_FORCE, K_PAUSE, K_START,
    K_READ, K_WRITE, K_BAD} cmd_kind_t;
  typedef enum {H_IDLE, H_WAIT} host_state_t;
endpackage

// ==== logic/mailbox_link_if.sv ====
// register-access link between host end and device end; one clock shared,
// the serial bit protocol is abstracted to one request and one answer.
interface mailbox_link_if;
  import mailbox_pkg::*;
  logic req;
  logic wr;
  bus_addr_t bus_addr;
  byte_t reg_addr;
  byte_t wdata;
  logic done;
  logic ack;
  byte_t rdata;
  modport device (input req, wr, bus_addr, reg_addr, wdata,
    output done, ack, rdata);
  modport host (output req, wr, bus_addr, reg_addr, wdata,
    input done, ack, rdata);
endinterface

// ==== logic/mailbox_device.sv ====
// device end: mailbox registers, hidden parameter table, command engine.
// assumes a host that keeps one access outstanding on the shared clock.
//
// The register offsets and the APB slave port were chosen for this implementation.
`include "mailbox_map.svh"
module mailbox_device
  import mailbox_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // link to the host
  mailbox_link_if.device LINK,
  // address strap pin, high selects primary
  input wire logic ADDR_SELECT,
  // measurement control towards the sequencer
  output logic FORCE_PULSE,
  output logic [5:0] FORCE_MASK,
  output logic [5:0] AUTO_MASK,
  // current bus address
  output logic [6:0] OWN_ADDR
);
  // command decode, one place for all code classes
  function automatic cmd_kind_t decode(input byte_t c);
    cmd_kind_t k;
    k = K_BAD;
    if (c[7:6] == `CMD_READ_TAG) k = K_READ;
    else if (c[7:6] == `CMD_WRITE_TAG) k = K_WRITE;
    else if (c == `CMD_CLEAR) k = K_CLEAR;
    else if (c == `CMD_SOFT_RESET) k = K_SOFT;
    else if (c == `CMD_NEW_ADDR) k = K_NEW_ADDR;
    else if (c == `CMD_FORCE) k = K_FORCE;
    else if (c == `CMD_PAUSE) k = K_PAUSE;
    else if (c == `CMD_START) k = K_START;
    return k;
  endfunction

  // a channel is periodic when its config selects a counter index
  function automatic logic has_index(input byte_t cfg);
    return |cfg[7:6];
  endfunction

  byte_t table_reg [`TABLE_DEPTH];
  byte_t staging_reg;
  byte_t command_reg;
  byte_t result_reg;
  byte_t response_reg;
  logic cmd_pend_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic [1:0] init_cnt_reg;
  bus_addr_t addr_reg;
  logic done_reg;
  logic ack_reg;
  byte_t rdata_reg;
  logic force_reg;
  logic [5:0] force_mask_reg;
  logic [5:0] auto_mask_reg;

  // decoded command and its operands
  cmd_kind_t kind;
  logic [5:0] location;
  logic loc_bad;
  logic [5:0] channel_enable_list;
  logic [5:0] indexed;
  logic [6:0] out_bytes;
  logic over_area;
  logic cmd_err;
  logic exec;
  logic soft_reset;
  logic ready;
  logic hit;
  logic wr_hit;
  byte_t read_mux;

  assign kind = decode(command_reg);
  assign location = command_reg[5:0];
  assign loc_bad = location > `TABLE_LAST;
  assign channel_enable_list = table_reg[`LOC_CHANNEL_ENABLE_LIST][5:0];
  assign exec = cmd_pend_reg;
  assign soft_reset = exec && (kind == K_SOFT);
  assign ready = init_cnt_reg == `INIT_DONE;

  // per-channel counter index check
  genvar g;
  generate
    for (g = 0; g < `CHANNELS; g++) begin : g_chan
      assign indexed[g] = has_index(table_reg[`LOC_MEASCFG0 +
        6'(`LOC_STRIDE * g)]);
    end
  endgenerate

  // output area: 2 or 3 bytes per enabled channel, doubled in burst
  always_comb begin
    logic [6:0] sum;
    sum = 7'h00;
    for (int i = 0; i < `CHANNELS; i++) begin
      if (channel_enable_list[i]) begin
        if (table_reg[`LOC_ADCPOST0 + 6'(`LOC_STRIDE * i)][`WIDE_BIT])
          sum = sum + 7'h03;
        else
          sum = sum + 7'h02;
      end
    end
    if (table_reg[`LOC_BURST][`BURST_BIT])
      sum = 7'(sum << 1);
    out_bytes = sum;
  end

  assign over_area = out_bytes > `OUT_AREA;
  assign cmd_err = ((kind == K_READ || kind == K_WRITE) && loc_bad) ||
    ((kind == K_FORCE || kind == K_START) && over_area) ||
    (kind == K_BAD);

  // seven-bit match only, silent while starting up
  assign hit = LINK.req && ready && (LINK.bus_addr == addr_reg);
  assign wr_hit = hit && LINK.wr;
  // only mailbox registers are visible, table never
  assign read_mux = (LINK.reg_addr == `REG_STAGING) ? staging_reg :
    (LINK.reg_addr == `REG_COMMAND) ? command_reg :
    (LINK.reg_addr == `REG_RESULT) ? result_reg :
    (LINK.reg_addr == `REG_RESPONSE) ? response_reg : 8'h00;

  // strap synchroniser; the pin is asynchronous to CLOCK
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= ADDR_SELECT;
      sync2_reg <= sync1_reg;
    end
  end

  // startup count: strap is trusted once two edges have passed
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      init_cnt_reg <= 2'h0;
    else if (soft_reset)
      init_cnt_reg <= 2'h0;
    else if (!ready)
      init_cnt_reg <= init_cnt_reg + 2'h1;
  end

  // bus address: strap at startup, programmable until next reset
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      addr_reg <= `PRIMARY_ADDR;
    end else if (init_cnt_reg == `INIT_DONE - 2'h1) begin
      addr_reg <= sync2_reg ? `PRIMARY_ADDR : `ALTERNATE_ADDR;
    end else if (exec && kind == K_NEW_ADDR) begin
      addr_reg <= table_reg[`LOC_NEW_ADDR][6:0];
    end
  end

  // link answer, one cycle after each request
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      done_reg <= LINK.req;
      ack_reg <= hit;
      rdata_reg <= hit ? read_mux : 8'h00;
    end
  end

  // host-writable mailbox registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      staging_reg <= 8'h00;
      command_reg <= 8'h00;
      cmd_pend_reg <= 1'b0;
    end else if (soft_reset) begin
      staging_reg <= 8'h00;
      command_reg <= 8'h00;
      cmd_pend_reg <= 1'b0;
    end else begin
      cmd_pend_reg <= wr_hit && LINK.reg_addr == `REG_COMMAND;
      if (wr_hit && LINK.reg_addr == `REG_STAGING)
        staging_reg <= LINK.wdata;
      if (wr_hit && LINK.reg_addr == `REG_COMMAND)
        command_reg <= LINK.wdata;
    end
  end

  // parameter table; volatile, no reset-free storage
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < `TABLE_DEPTH; i++)
        table_reg[i] <= `TABLE_DEFAULT;
    end else if (soft_reset) begin
      for (int i = 0; i < `TABLE_DEPTH; i++)
        table_reg[i] <= `TABLE_DEFAULT;
    end else if (exec && kind == K_WRITE && !cmd_err) begin
      table_reg[location] <= staging_reg;
    end
  end

  // result and response registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      result_reg <= 8'h00;
      response_reg <= `RESPONSE_RESET;
    end else if (soft_reset) begin
      result_reg <= 8'h00;
      response_reg <= `RESPONSE_RESET;
    end else if (exec) begin
      if (kind == K_CLEAR) begin
        response_reg[3:0] <= 4'h0;
        response_reg[`ERR_BIT] <= 1'b0;
      end else if (cmd_err) begin
        response_reg[`ERR_BIT] <= 1'b1;
      end else begin
        response_reg[3:0] <= response_reg[3:0] + 4'h1;
        if (kind == K_WRITE)
          result_reg <= staging_reg;
        else if (kind == K_READ)
          result_reg <= table_reg[location];
      end
    end
  end

  // measurement control; area check blocks oversized setups
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      force_reg <= 1'b0;
      force_mask_reg <= 6'h00;
      auto_mask_reg <= 6'h00;
    end else if (soft_reset) begin
      force_reg <= 1'b0;
      force_mask_reg <= 6'h00;
      auto_mask_reg <= 6'h00;
    end else begin
      force_reg <= exec && kind == K_FORCE && !cmd_err;
      if (exec && kind == K_FORCE && !cmd_err)
        force_mask_reg <= channel_enable_list & ~indexed;
      if (exec && kind == K_PAUSE)
        auto_mask_reg <= auto_mask_reg & ~channel_enable_list;
      else if (exec && kind == K_START && !cmd_err)
        auto_mask_reg <= auto_mask_reg | (channel_enable_list & indexed);
    end
  end

  // outputs
  assign LINK.done = done_reg;
  assign LINK.ack = ack_reg;
  assign LINK.rdata = rdata_reg;
  assign FORCE_PULSE = force_reg;
  assign FORCE_MASK = force_mask_reg;
  assign AUTO_MASK = auto_mask_reg;
  assign OWN_ADDR = addr_reg;
endmodule

// ==== logic/mailbox_host.sv ====
// host end: apb slave that turns software orders into link accesses.
// assumes software sequences commands; one access in flight at a time.
`include "mailbox_map.svh"
module mailbox_host
  import mailbox_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // link to the device
  mailbox_link_if.host LINK
);
  host_state_t state_reg;
  logic req_reg;
  logic wr_reg;
  bus_addr_t bus_addr_reg;
  byte_t reg_addr_reg;
  byte_t wdata_reg;
  logic ack_reg;
  byte_t rdata_reg;

  logic busy;
  logic acc_sel;
  logic sts_sel;
  logic launch;
  // address decode
  assign busy = state_reg == H_WAIT;
  assign acc_sel = PADDR == `APB_ACCESS;
  assign sts_sel = PADDR == `APB_STATUS;
  // a new access waits for the last one
  assign PREADY = !(PSEL && PENABLE && PWRITE && acc_sel && busy);
  assign launch = PSEL && PENABLE && PWRITE && acc_sel && !busy;
  assign PSLVERR = PSEL && PENABLE && !acc_sel && !sts_sel;
  // software polls status for the byte returned by the last link access, read or write
  assign PRDATA = !(PSEL && sts_sel) ? 32'h0000_0000 :
    {16'h0000, rdata_reg, 6'h00, ack_reg, busy};

  // access engine, stalls apb instead of queueing
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= H_IDLE;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      bus_addr_reg <= 7'h00;
      reg_addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      req_reg <= launch;
      unique case (state_reg)
        H_IDLE: begin
          if (launch) begin
            state_reg <= H_WAIT;
            reg_addr_reg <= PWDATA[7:0];
            wdata_reg <= PWDATA[15:8];
            bus_addr_reg <= PWDATA[22:16];
            wr_reg <= PWDATA[`ACC_WR_BIT];
          end
        end
        H_WAIT: begin
          if (LINK.done) begin
            state_reg <= H_IDLE;
            ack_reg <= LINK.ack;
            rdata_reg <= LINK.rdata;
          end
        end
      endcase
    end
  end

  // link drive
  assign LINK.req = req_reg;
  assign LINK.wr = wr_reg;
  assign LINK.bus_addr = bus_addr_reg;
  assign LINK.reg_addr = reg_addr_reg;
  assign LINK.wdata = wdata_reg;
endmodule

// ==== testbench/mailbox_monitor.sv ====
// link checker: answer timing, response and result bytes on the link.
// assumes one command between response reads, as the bench keeps it.
`include "mailbox_map.svh"
module mailbox_monitor
  import mailbox_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire bus_addr_t bus_addr,
  input wire byte_t reg_addr,
  input wire byte_t wdata,
  input wire logic done,
  input wire logic ack,
  input wire byte_t rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  byte_t cmd_reg;
  byte_t stage_reg;
  byte_t prev_reg;
  logic fresh_reg;
  // answered link events only; a refused access changes nothing
  wire ok = done && ack;
  wire rd_rsp = ok && !wr && reg_addr == `REG_RESPONSE;
  wire rd_res = ok && !wr && reg_addr == `REG_RESULT;
  wire wr_cmd = ok && wr && reg_addr == `REG_COMMAND;
  wire wr_stg = ok && wr && reg_addr == `REG_STAGING;
  wire [1:0] tag = cmd_reg[7:6];
  wire tbl_op = tag == `CMD_READ_TAG || tag == `CMD_WRITE_TAG;
  wire bad_loc = tbl_op && cmd_reg[5:0] > `TABLE_LAST;
  wire good = (tbl_op && !bad_loc) || cmd_reg == `CMD_PAUSE ||
    cmd_reg == `CMD_NEW_ADDR;
  // last command, staging byte and response seen on the link
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_reg <= `CMD_SOFT_RESET; // reset reads like a soft reset
      stage_reg <= 8'h00;
      prev_reg <= `RESPONSE_RESET;
      fresh_reg <= 1'b0;
    end else begin
      if (wr_cmd) cmd_reg <= wdata;
      if (wr_stg) stage_reg <= wdata;
      if (rd_rsp) prev_reg <= rdata;
      fresh_reg <= wr_cmd || (fresh_reg && !rd_rsp);
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // answer framing
  a_done_next: assert property (req |=> done)
    else $error("no answer one cycle after request");
  a_done_cause: assert property (done |-> $past(req))
    else $error("answer without request");
  a_ack_in_done: assert property (ack |-> done)
    else $error("ack outside answer");
  a_nack_quiet: assert property (done && !ack |-> rdata == 8'h00)
    else $error("refused access returned data");
  // command effects seen through the mailbox registers
  a_write_echo: assert property (
    rd_res && tag == `CMD_WRITE_TAG && !bad_loc |-> rdata == stage_reg)
    else $error("result is not the written byte");
  a_clear_zero: assert property (
    rd_rsp && cmd_reg == `CMD_CLEAR |-> rdata[4:0] == 5'h00)
    else $error("counter or error left after clear");
  a_soft_value: assert property (
    rd_rsp && cmd_reg == `CMD_SOFT_RESET |-> rdata == `RESPONSE_RESET)
    else $error("response wrong after reset");
  a_bad_flag: assert property (rd_rsp && bad_loc |->
    rdata[`ERR_BIT] && rdata[3:0] == prev_reg[3:0])
    else $error("bad location not flagged");
  a_count_step: assert property (
    rd_rsp && fresh_reg && good && !prev_reg[`ERR_BIT] |->
    rdata[3:0] == prev_reg[3:0] + 4'h1)
    else $error("counter did not step by one");
  c_cmd: cover property (wr_cmd);
  c_err: cover property (rd_rsp && rdata[`ERR_BIT]);
  c_foreign: cover property (req && bus_addr != `PRIMARY_ADDR);
endmodule

// ==== testbench/tb_top.sv ====
// top bench: apb orders into the host end, device end across the link.
// assumes one shared clock and the link checker beside the interface.
`include "mailbox_map.svh"
module tb_top
  import mailbox_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, strap, psel, penable, pwrite, pready, pslverr, perr;
  logic force_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prd;
  logic [5:0] force_mask, auto_mask, fmask, amask, loc;
  logic [6:0] own_addr;
  bus_addr_t own;
  byte_t rsp, res;
  byte_t tbl [64];
  logic [8:0] exp_q [$];
  int seed, error_cnt, tests_run, cycles, pulses, nforce;
  logic [15:0] plan [21] = '{16'h95a5, 16'h0100, 16'h5500, 16'h813f,
    16'h8540, 16'h1100, 16'h1300, 16'h1200, 16'hab80, 16'h8440, 16'h1100,
    16'h8840, 16'h1300, 16'h0000, 16'h0300, 16'h0100, 16'hbf55, 16'h7f00,
    16'h0000, 16'h80d5, 16'h0200};
  mailbox_link_if lnk ();
  mailbox_host i_mailbox_host (.CLOCK(clock), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(lnk.host));
  mailbox_device i_mailbox_device (.CLOCK(clock), .RSTN(rstn),
    .LINK(lnk.device), .ADDR_SELECT(strap), .FORCE_PULSE(force_pulse),
    .FORCE_MASK(force_mask), .AUTO_MASK(auto_mask), .OWN_ADDR(own_addr));
  mailbox_monitor i_mailbox_monitor (.CLOCK(clock), .RSTN(rstn),
    .req(lnk.req), .wr(lnk.wr), .bus_addr(lnk.bus_addr),
    .reg_addr(lnk.reg_addr), .wdata(lnk.wdata), .done(lnk.done),
    .ack(lnk.ack), .rdata(lnk.rdata));
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, then one idle cycle so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // link access; reads note the expected {ack, data} first
  task automatic acc(input logic w, input bus_addr_t ba, input byte_t ra,
    input byte_t d, input logic [8:0] e);
    if (!w) exp_q.push_back(e);
    apb(1'b1, `APB_ACCESS, {7'h00, w, 1'b0, ba, d, ra});
  endtask
  // two link reads and a status read with no idle cycle between them: the
  // second read stalls on pready, the status read lands while it is in flight
  task automatic acc_pair(input bus_addr_t ba, input logic [8:0] e);
    int waits;
    waits = 0;
    exp_q.push_back(e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= `APB_ACCESS;
    pwdata <= {7'h00, 1'b0, 1'b0, ba, 8'h00, `REG_RESPONSE};
    repeat (2) begin
      @(posedge clock);
      penable <= 1'b1;
      do begin
        @(posedge clock);
        waits++;
      end while (pready !== 1'b1);
      penable <= 1'b0;
    end
    // next setup follows at once, so psel stays high
    paddr <= `APB_STATUS;
    pwrite <= 1'b0;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    prd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    check("stall cycles", waits, 3);
    check("busy status", 32'({prd[15:8], prd[1:0]}),
      32'({e[7:0], e[8], 1'b1}));
  endtask
  task automatic fresh_model();
    foreach (tbl[i]) tbl[i] = `TABLE_DEFAULT;
    rsp = `RESPONSE_RESET;
    res = 8'h00;
    own = strap ? `PRIMARY_ADDR : `ALTERNATE_ADDR;
    fmask = 6'h00;
    amask = 6'h00;
  endtask
  task automatic hw_reset(input logic s);
    strap <= s;
    rstn <= 1'b0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock); // startup window of the device
    fresh_model();
  endtask
  // one command with its expected response, result and outputs
  task automatic run(input byte_t c, input byte_t s);
    logic tb_op, bad;
    logic [5:0] en, idx;
    int sz;
    tb_op = c[7:6] == `CMD_READ_TAG || c[7:6] == `CMD_WRITE_TAG;
    en = tbl[`LOC_CHANNEL_ENABLE_LIST][5:0];
    sz = 0;
    for (int n = 0; n < `CHANNELS; n++) begin
      idx[n] = tbl[`LOC_MEASCFG0 + `LOC_STRIDE * n][7:6] != 2'h0;
      if (en[n]) sz += tbl[`LOC_ADCPOST0 + `LOC_STRIDE * n][`WIDE_BIT] ? 3 : 2;
    end
    if (tbl[`LOC_BURST][`BURST_BIT]) sz *= 2;
    bad = tb_op ? c[5:0] > `TABLE_LAST :
      !(c inside {8'h00, 8'h01, 8'h02, 8'h11, 8'h12, 8'h13}) ||
      ((c == `CMD_FORCE || c == `CMD_START) && sz > `OUT_AREA);
    if (c[7:6] == `CMD_WRITE_TAG) acc(1'b1, own, `REG_STAGING, s, 9'h000);
    acc(1'b1, own, `REG_COMMAND, c, 9'h000);
    if (bad) rsp[`ERR_BIT] = 1'b1;
    else if (c == `CMD_CLEAR) rsp[4:0] = 5'h00;
    else if (c == `CMD_SOFT_RESET) begin
      fresh_model();
      repeat (6) @(posedge clock); // device deaf after a soft reset
    end else begin
      rsp[3:0] = rsp[3:0] + 4'h1;
      if (c[7:6] == `CMD_WRITE_TAG) tbl[c[5:0]] = s;
      if (tb_op) res = tbl[c[5:0]];
      if (c == `CMD_NEW_ADDR) own = tbl[`LOC_NEW_ADDR][6:0];
      if (c == `CMD_FORCE) fmask = en & ~idx;
      if (c == `CMD_FORCE) nforce++;
      if (c == `CMD_START) amask = amask | (en & idx);
      if (c == `CMD_PAUSE) amask = amask & ~en;
    end
    acc(1'b0, own, `REG_RESPONSE, 8'h00, {1'b1, rsp});
    acc(1'b0, own, `REG_RESULT, 8'h00, {1'b1, res});
    apb(1'b0, `APB_STATUS, 32'h0);
    check("status", 32'({prd[15:8], prd[1:0]}), 32'({res, 2'h2}));
    check("auto mask", 32'(auto_mask), 32'(amask));
    check("force mask", 32'(force_mask), 32'(fmask));
    check("force pulses", pulses, nforce);
    check("bus address", 32'(own_addr), 32'(own));
  endtask
  // link read scoreboard, pulse count and watchdog
  always @(posedge clock) begin
    if (lnk.done === 1'b1 && lnk.wr === 1'b0) begin
      if (exp_q.size() == 0) check("stray read", 32'h1, 32'h0);
      else check("link read", 32'({lnk.ack, lnk.rdata}),
        32'(exp_q.pop_front()));
    end
    if (force_pulse === 1'b1) pulses++;
    cycles++;
    // about forty commands of under twenty cycles each, so ample
    if (cycles == 30000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    seed = 38672;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rstn = 1'b0;
    strap = 1'b1;
    hw_reset(1'b1);
    acc(1'b0, own, `REG_RESPONSE, 8'h00, 9'h12f);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped", {prd[30:0], perr}, 32'h1);
    acc_pair(own, 9'h12f);
    repeat (6) begin
      loc = 6'(($random(seed) & 32'h7fff_ffff) % 46);
      run({`CMD_WRITE_TAG, loc}, 8'($random(seed)));
      run({`CMD_READ_TAG, loc}, 8'h00);
    end
    foreach (plan[i]) run(plan[i][15:8], plan[i][7:0]);
    acc(1'b0, `PRIMARY_ADDR, `REG_RESPONSE, 8'h00, 9'h000);
    run(`CMD_SOFT_RESET, 8'h00);
    run(8'h80, 8'hd5);
    run(`CMD_NEW_ADDR, 8'h00);
    hw_reset(1'b0);
    run(`CMD_PAUSE, 8'h00);
    acc(1'b0, `PRIMARY_ADDR, `REG_RESPONSE, 8'h00, 9'h000);
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule
